//--- hdl/mode_sysctl_pkg.sv
// Package with register map, field layout and reset values of the mode and system control bank
package mode_sysctl_pkg;
    localparam logic [3:0] MODE_STATUS_OFFSET = 4'h0;
    localparam logic [3:0] SYSTEM_CONTROL_OFFSET = 4'h4;
    localparam logic [3:0] MODE_STATUS_LAYOUT_UNUSED = 4'h0;
    localparam int MODE_STATUS_TOP_BIT = 7;
    localparam int MAC_SATURATE_BIT = 7;
    localparam int IRQ_MODE_HI_BIT = 5;
    localparam int IRQ_MODE_LO_BIT = 4;
    localparam int NMI_EDGE_BIT = 3;
    localparam int RAM_ENABLE_BIT = 0;
    localparam logic [7:0] MODE_STATUS_WMASK = 8'h80;
    localparam logic [7:0] SYSTEM_CONTROL_WMASK = 8'hb9;
    localparam logic [7:0] MODE_STATUS_RESET = 8'h80;
    localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h01;
    localparam logic [2:0] SUPPORTED_MODE_PINS = 3'h7;
    localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;
    localparam logic [1:0] IRQ_MODE_0 = 2'h0;
    localparam logic [1:0] IRQ_MODE_2 = 2'h2;
    localparam int MEM_SPACE_BYTES = 16777216;

    typedef struct packed {
        logic mac_saturate_sel;
        logic [1:0] irq_ctrl_mode;
        logic nmi_edge_sel;
        logic onchip_ram_enable;
    } sys_ctrl_s;
endpackage

//--- hdl/mode_system_control_regs.sv
// Mode status and system control register bank with AXI4-Lite slave
//
// What this block does
// - Reserved bits read zero, ignore writes
// - Mode status bits latch pins on read
// - Reset clears latched mode pin copies
// - Bit 7 selects saturating multiply-accumulate
// - Bits 5:4 pick interrupt mode, 01/11 banned; write mask still stores 01/11
// - Bit 3 selects NMI active edge
// - Bit 0 enables on-chip RAM, resets one
// - RAM enable restored at reset release
// - Single-chip: on-chip ROM, no external access
// - All port pins are general-purpose
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module mode_system_control_regs (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic mode_pin_hi,
    input wire logic mode_pin_mid,
    input wire logic mode_pin_lo,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mac_saturate_sel,
    output logic [1:0] irq_ctrl_mode,
    output logic nmi_edge_sel,
    output logic onchip_ram_enable,
    output logic onchip_rom_enable,
    output logic external_bus_enable,
    output logic ports_general_purpose,
    output logic mode_pins_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pins_meta_q;
    logic [2:0] pins_sync_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_meta_q <= 3'h0;
            pins_sync_q <= 3'h0;
        end else begin
            pins_meta_q <= {mode_pin_hi, mode_pin_mid, mode_pin_lo};
            pins_sync_q <= pins_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data accepted in either order
    logic aw_held_q;
    logic [3:0] aw_addr_q;
    logic w_held_q;
    logic [7:0] w_byte_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [3:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [7:0] wr_byte = w_held_q ? w_byte_q : s_axi_wdata[7:0];
    wire wr_lane = w_held_q ? w_lane_q : s_axi_wstrb[0];
    wire aw_have = aw_held_q || aw_take;
    wire w_have = w_held_q || w_take;
    wire wr_fire = aw_have && w_have && !bvalid_q;
    wire wr_hit_mode = wr_addr == mode_sysctl_pkg::MODE_STATUS_OFFSET;
    wire wr_hit_sys = wr_addr == mode_sysctl_pkg::SYSTEM_CONTROL_OFFSET;
    wire wr_mapped = wr_hit_mode || wr_hit_sys;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_held_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= mode_sysctl_pkg::AXI_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? mode_sysctl_pkg::AXI_RESP_OKAY
                                     : mode_sysctl_pkg::AXI_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    w_byte_q <= s_axi_wdata[7:0];
                    w_lane_q <= s_axi_wstrb[0];
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] mode_status_q;
    logic [7:0] system_control_q;
    logic [7:0] mode_status_d;
    logic [7:0] system_control_d;

    wire wr_commit = wr_fire && wr_lane;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire rd_hit_mode = s_axi_araddr == mode_sysctl_pkg::MODE_STATUS_OFFSET;
    wire rd_hit_sys = s_axi_araddr == mode_sysctl_pkg::SYSTEM_CONTROL_OFFSET;
    wire mode_latch = rd_take && rd_hit_mode;

    function automatic logic [7:0] masked_write(input logic [7:0] old_val,
                                                 input logic [7:0] new_val,
                                                 input logic [7:0] wmask);
        masked_write = (old_val & ~wmask) | (new_val & wmask);
    endfunction

    always_comb begin
        mode_status_d = mode_status_q;
        if (wr_commit && wr_hit_mode) begin
            mode_status_d = masked_write(mode_status_q, wr_byte,
                                         mode_sysctl_pkg::MODE_STATUS_WMASK);
        end
        if (mode_latch) begin
            mode_status_d[2:0] = pins_sync_q;
        end
        mode_status_d[6:3] = mode_sysctl_pkg::MODE_STATUS_LAYOUT_UNUSED;
    end

    always_comb begin
        system_control_d = system_control_q;
        if (wr_commit && wr_hit_sys) begin
            system_control_d = masked_write(system_control_q, wr_byte,
                                            mode_sysctl_pkg::SYSTEM_CONTROL_WMASK);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_status_q <= mode_sysctl_pkg::MODE_STATUS_RESET;
            system_control_q <= mode_sysctl_pkg::SYSTEM_CONTROL_RESET;
        end else begin
            mode_status_q <= mode_status_d;
            system_control_q <= system_control_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire [7:0] mode_status_view = {mode_status_q[7], 4'h0, pins_sync_q};
    wire [7:0] rd_byte = rd_hit_mode ? mode_status_view
                       : rd_hit_sys ? system_control_q : 8'h00;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= mode_sysctl_pkg::AXI_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= (rd_hit_mode || rd_hit_sys) ? mode_sysctl_pkg::AXI_RESP_OKAY
                                                    : mode_sysctl_pkg::AXI_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control outputs
    assign mac_saturate_sel = system_control_q[mode_sysctl_pkg::MAC_SATURATE_BIT];
    assign irq_ctrl_mode = {system_control_q[mode_sysctl_pkg::IRQ_MODE_HI_BIT],
                            system_control_q[mode_sysctl_pkg::IRQ_MODE_LO_BIT]};
    assign nmi_edge_sel = system_control_q[mode_sysctl_pkg::NMI_EDGE_BIT];
    assign onchip_ram_enable = system_control_q[mode_sysctl_pkg::RAM_ENABLE_BIT];
    assign onchip_rom_enable = 1'b1;
    assign external_bus_enable = 1'b0;
    assign ports_general_purpose = 1'b1;
    // Latched pins report the supported mode
    assign mode_pins_valid = mode_status_q[2:0] == mode_sysctl_pkg::SUPPORTED_MODE_PINS;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    mode_reserved_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_status_q[6:3] == 4'h0)
        else $error("mode status reserved bits not zero");

    sys_reserved_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        system_control_q[6] == 1'b0 && system_control_q[2:1] == 2'h0)
        else $error("system control reserved bits not zero");

    pin_latch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mode_latch |=> mode_status_q[2:0] == $past(pins_sync_q))
        else $error("mode pins not latched on read");

    pin_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !mode_latch |=> $stable(mode_status_q[2:0]))
        else $error("mode copy changed without read");

    sys_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_commit && wr_hit_sys) |=> system_control_q == ($past(wr_byte) & 8'hb9))
        else $error("system control write wrong");

    sys_stable_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(wr_commit && wr_hit_sys) |=> $stable(system_control_q))
        else $error("system control changed without write");

    ram_enable_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        onchip_ram_enable == system_control_q[0] && nmi_edge_sel == system_control_q[3])
        else $error("control output mismatch");

    write_resp_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_fire |=> s_axi_bvalid && (s_axi_bresp == 2'h0) == $past(wr_mapped))
        else $error("write response wrong");

    read_resp_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_take && rd_hit_sys) |=> s_axi_rvalid
            && s_axi_rdata == {24'h00_0000, $past(system_control_q)})
        else $error("read data wrong");

    mode_top_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_commit && wr_hit_mode) |=> mode_status_q[7] == $past(wr_byte[7]))
        else $error("mode status bit 7 not written");

    write_busy_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_fire |=> !s_axi_awready && !s_axi_wready)
        else $error("write channels open while response pending");

    bresp_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");

    rresp_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not retired");

    bad_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_take && !rd_hit_mode && !rd_hit_sys) |=> s_axi_rdata == 32'h0000_0000
            && s_axi_rresp == mode_sysctl_pkg::AXI_RESP_SLVERR)
        else $error("unmapped read answer wrong");

    mode_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_take && rd_hit_mode) |=> s_axi_rdata[6:3] == 4'h0
            && s_axi_rdata[2:0] == $past(pins_sync_q))
        else $error("mode status read data wrong");

    mode_top_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_take && rd_hit_mode) |=> s_axi_rdata[7] == $past(mode_status_q[7]))
        else $error("mode status bit 7 read wrong");

    upper_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data upper bytes not zero");

    bad_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_fire && !wr_mapped && !mode_latch) |=> $stable(system_control_q)
            && $stable(mode_status_q))
        else $error("unmapped write changed a register");

    lane_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_fire && !wr_lane && !mode_latch) |=> $stable(system_control_q)
            && $stable(mode_status_q))
        else $error("write without byte lane changed a register");

    pins_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_commit && wr_hit_mode && !mode_latch) |=> $stable(mode_status_q[2:0]))
        else $error("write reached mode pin copy");

    reset_irq_a: assert property (@(posedge sys_clk)
        $rose(reset_n) |-> irq_ctrl_mode == mode_sysctl_pkg::IRQ_MODE_0)
        else $error("interrupt mode not cleared by reset");

    reset_mac_a: assert property (@(posedge sys_clk)
        $rose(reset_n) |-> !mac_saturate_sel)
        else $error("saturation select not cleared by reset");

    reset_nmi_a: assert property (@(posedge sys_clk)
        $rose(reset_n) |-> !nmi_edge_sel)
        else $error("nmi edge select not cleared by reset");

    reset_ram_a: assert property (@(posedge sys_clk)
        $rose(reset_n) |-> onchip_ram_enable)
        else $error("ram enable not restored at reset release");

    reset_pins_a: assert property (@(posedge sys_clk)
        $rose(reset_n) |-> !mode_pins_valid
            && mode_status_q == mode_sysctl_pkg::MODE_STATUS_RESET)
        else $error("mode pin copy not released by reset");

    irq_legal_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        irq_ctrl_mode == mode_sysctl_pkg::IRQ_MODE_0
            || irq_ctrl_mode == mode_sysctl_pkg::IRQ_MODE_2)
        else $error("prohibited interrupt mode present");

    mac_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_commit && wr_hit_sys) |=> mac_saturate_sel == $past(wr_byte[7]))
        else $error("saturation select does not follow write");

    irq_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_commit && wr_hit_sys) |=> irq_ctrl_mode == $past(wr_byte[5:4]))
        else $error("interrupt mode does not follow write");

    nmi_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_commit && wr_hit_sys) |=> nmi_edge_sel == $past(wr_byte[3]))
        else $error("nmi edge select does not follow write");

    ram_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_commit && wr_hit_sys) |=> onchip_ram_enable == $past(wr_byte[0]))
        else $error("ram enable does not follow write");

    pins_valid_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mode_latch && pins_sync_q == mode_sysctl_pkg::SUPPORTED_MODE_PINS)
            |=> mode_pins_valid)
        else $error("supported mode not reported after read");

    sync_delay_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> pins_sync_q == $past(pins_meta_q))
        else $error("mode pin synchroniser stage skipped");

endmodule

//--- tb/mode_system_control_regs_test.sv
// Self-checking bench for the mode and system control register bank
`timescale 1ns/1ns
module mode_system_control_regs_test;
    localparam logic [3:0] MS = mode_sysctl_pkg::MODE_STATUS_OFFSET;
    localparam logic [3:0] SC = mode_sysctl_pkg::SYSTEM_CONTROL_OFFSET;
    localparam logic [1:0] OK = mode_sysctl_pkg::AXI_RESP_OKAY;
    localparam logic [1:0] ERR = mode_sysctl_pkg::AXI_RESP_SLVERR;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic mode_pin_hi = 1'b1, mode_pin_mid = 1'b1, mode_pin_lo = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, irq_ctrl_mode;
    logic [31:0] s_axi_rdata;
    logic mac_saturate_sel, nmi_edge_sel, onchip_ram_enable, onchip_rom_enable;
    logic external_bus_enable, ports_general_purpose, mode_pins_valid;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    int bad_count = 0;
    int samples_checked = 0;
    logic [15:0] lfsr = 16'h33a1;
    logic [7:0] d;
    logic [2:0] pat [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
    wire logic [8:0] outs = {mode_pins_valid, onchip_rom_enable, external_bus_enable,
        ports_general_purpose, mac_saturate_sel, irq_ctrl_mode, nmi_edge_sel, onchip_ram_enable};

    mode_system_control_regs uut (
        .sys_clk, .reset_n, .mode_pin_hi, .mode_pin_mid, .mode_pin_lo, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .mac_saturate_sel, .irq_ctrl_mode, .nmi_edge_sel, .onchip_ram_enable,
        .onchip_rom_enable, .external_bus_enable, .ports_general_purpose, .mode_pins_valid
    );

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic final_report();
        bad_count += exp_r.size() + exp_b.size();
        $display("Compared %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic compare(input string n, input logic [33:0] e, input logic [33:0] s);
        samples_checked++;
        if (e !== s) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic check_read(input logic [33:0] e);
        compare("read", e, {s_axi_rresp, s_axi_rdata});
    endtask

    task automatic check_resp(input logic [1:0] e);
        compare("bresp", {32'h0000_0000, e}, {32'h0000_0000, s_axi_bresp});
    endtask

    task automatic check_out(input logic [8:0] e);
        compare("outputs", {25'h000_0000, e}, {25'h000_0000, outs});
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic do_reset(input logic [2:0] p);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        @(posedge sys_clk);
        {mode_pin_hi, mode_pin_mid, mode_pin_lo} <= p;
        repeat (15) @(posedge sys_clk);
        reset_n <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus_write(input logic [3:0] a, input logic [7:0] v, input logic [3:0] st,
                             input logic [1:0] r);
        logic aw_p, w_p, b_p, aw_h, w_h, b_h;
        int n;
        @(posedge sys_clk);
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {lfsr_next(lfsr), 8'h00, v};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        {aw_p, w_p, b_p} = 3'h7;
        for (n = 0; n < 64 && b_p; n++) begin
            #1;
            aw_h = aw_p && s_axi_awready;
            w_h = w_p && s_axi_wready;
            b_h = s_axi_bvalid;
            @(posedge sys_clk);
            if (aw_h) begin
                s_axi_awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_h) begin
                s_axi_wvalid <= 1'b0;
                w_p = 1'b0;
            end
            if (b_h) begin
                s_axi_bready <= 1'b0;
                b_p = 1'b0;
            end
        end
        if (b_p) begin
            bad_count++;
            final_report();
        end
    endtask

    task automatic bus_read(input logic [3:0] a, input logic [7:0] v, input logic [1:0] r);
        logic r_p;
        int n;
        @(posedge sys_clk);
        exp_r.push_back({r, 24'h00_0000, v});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r_p = 1'b1;
        for (n = 0; n < 64 && r_p; n++) begin
            #1;
            if (s_axi_arready) begin
                @(posedge sys_clk);
                s_axi_arvalid <= 1'b0;
                #1;
            end
            r_p = !s_axi_rvalid;
            @(posedge sys_clk);
        end
        s_axi_rready <= 1'b0;
        if (r_p) begin
            bad_count++;
            final_report();
        end
    endtask

    // Results are paired with the oldest note when they appear
    always @(posedge sys_clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            check_read(exp_r.size() > 0 ? exp_r.pop_front() : 34'h3_ffff_ffff);
        end
        if (s_axi_bvalid && s_axi_bready) begin
            check_resp(exp_b.size() > 0 ? exp_b.pop_front() : 2'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(3'h7);
        tick(4);
        check_out(9'h0a1);
        bus_read(SC, 8'h01, OK);
        bus_read(MS, 8'h87, OK);
        tick(1);
        check_out(9'h1a1);
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            d = lfsr[7:0] & 8'hef;
            bus_write(SC, d, 4'hf, OK);
            bus_write(SC, ~d, 4'he, OK);
            bus_read(SC, d & 8'hb9, OK);
            tick(1);
            check_out({4'hd, d[7], d[5:4], d[3], d[0]});
        end
        bus_write(MS, 8'hff, 4'hf, OK);
        bus_read(MS, 8'h87, OK);
        bus_write(4'h8, 8'h00, 4'hf, ERR);
        bus_read(4'hc, 8'h00, ERR);
        for (int i = 0; i < 4; i++) begin
            do_reset(pat[i]);
            tick(4);
            bus_read(MS, {5'h10, pat[i]}, OK);
            tick(1);
            check_out({pat[i] == 3'h7, 8'ha1});
        end
        bus_write(SC, 8'h00, 4'hf, OK);
        tick(1);
        check_out(9'h1a0);
        do_reset(3'h7);
        tick(1);
        check_out(9'h0a1);
        bus_read(SC, 8'h01, OK);
        tick(2);
        final_report();
    end
endmodule
